// >>> hdl/pri_pkg.sv
package pri_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_PS   = 20_000;
    // Minimum pulse widths in picoseconds (2.5 us and 0.125 us)
    localparam int unsigned SLOW_MIN_W_PS   = 2_500_000;
    localparam int unsigned FAST_MIN_W_PS   = 125_000;
    // Maximum pulse rates in pulses per second
    localparam int unsigned SLOW_MAX_PPS    = 200_000;
    localparam int unsigned FAST_MAX_PPS    = 4_000_000;
    // Least width rounds up to whole cycles
    localparam int unsigned SLOW_MIN_CYC    = (SLOW_MIN_W_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned FAST_MIN_CYC    = (FAST_MIN_W_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Least period between pulses, rounded down: a host at full rate may be
    // seen one cycle short after sampling and must not be flagged
    localparam int unsigned SLOW_PER_CYC    = CLK_HZ / SLOW_MAX_PPS;
    localparam int unsigned FAST_PER_CYC    = CLK_HZ / FAST_MAX_PPS;

    localparam int unsigned CNT_W           = 8;
    localparam int unsigned POS_W           = 32;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        PRI_FORM_STEP_DIR = 3'b001,
        PRI_FORM_QUAD     = 3'b010,
        PRI_FORM_CW_CCW   = 3'b100
    } pri_form_t;

    // One pair of reference lines
    typedef struct packed {
        logic a;  // Step, phase A or clockwise train
        logic b;  // Direction, phase B or counter-clockwise train
    } pri_pair_t;

    // Per-line width meter
    typedef struct packed {
        logic [CNT_W-1:0] high_cnt;
        logic [CNT_W-1:0] low_cnt;
    } pri_meter_t;

endpackage

// >>> hdl/pri_receiver.sv
`timescale 1ns/1ps

module pri_receiver
    import pri_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Configuration, held still while pulses flow
    input  wire pri_form_t        i_form,
    input  wire logic             i_fast_sel,
    input  wire logic             i_err_clear,
    // Reference lines from the host, taken as synchronous
    input  wire pri_pair_t        i_slow_pair,
    input  wire pri_pair_t        i_fast_pair,
    // Count and status, all straight from flops
    output logic signed [POS_W-1:0] o_position,
    output logic                  o_count_pulse,
    output logic                  o_count_up,
    output logic                  o_width_error,
    output logic                  o_rate_error,
    output logic                  o_both_active
);

    // ==========================================================
    // State
    // ==========================================================
    // sync1 and sync2 are the two synchroniser stages of the slow pair and
    // prev the stage after them; an edge is stage two differing from prev.
    // The f-prefixed fields do the same for the fast pair. Both pairs are
    // always synchronised so traffic on the unselected pair can be reported.
    // The run meters and the gap counter follow the selected pair only.
    // step, up and the three flags are the registered outputs; pos is the
    // signed count. Meter width must exceed the longest limit, the slow
    // period, so that a saturated run always reads as long enough.
    typedef struct packed {
        pri_pair_t                 sync1;
        pri_pair_t                 sync2;
        pri_pair_t                 prev;
        pri_pair_t                 fsync1;
        pri_pair_t                 fsync2;
        pri_pair_t                 fprev;
        pri_meter_t                meter_a;
        pri_meter_t                meter_b;
        logic [CNT_W-1:0]          gap_cnt;
        logic signed [POS_W-1:0]   pos;
        logic                      step;
        logic                      up;
        logic                      werr;
        logic                      rerr;
        logic                      both;
    } pri_state_t;

    pri_state_t st_reg;
    pri_state_t st_next;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Saturating increment so a long idle level never wraps into a short one
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 8'h01;
    endfunction

    // True when a level just ended and lasted at least two cycles less than the limit
    function automatic logic too_short(input logic [CNT_W-1:0] run,
                                       input logic [CNT_W-1:0] lim);
        // A saturated run is long by definition; adding one would wrap it to zero
        too_short = (run != {CNT_W{1'b1}}) && ((run + 8'h01) < lim);
    endfunction

    // True when a line just changed and the level it left was too short;
    // used for both lines so the two checks cannot drift apart
    function automatic logic level_short(input logic             now_v,
                                         input logic             was_v,
                                         input pri_meter_t       m,
                                         input logic [CNT_W-1:0] lim);
        level_short = (now_v != was_v) &&
                      too_short(was_v ? m.high_cnt : m.low_cnt, lim);
    endfunction

    // Per-cycle views of the selected pair, set on every pass of the comb process
    logic [CNT_W-1:0] min_w;
    logic [CNT_W-1:0] min_p;
    pri_pair_t        cur;
    pri_pair_t        old;
    logic             rise_a;
    logic             edge_a;
    logic             edge_b;
    logic             cnt_en;
    logic             cnt_up;

    // ==========================================================
    // Next state
    // ==========================================================
    // A line change reaches the count strobe three rising edges later:
    // stage one, stage two, then the registered strobe. Position and strobe
    // move on the same edge, so a watcher can rebuild the count from them.
    always_comb begin
        st_next = st_reg;
        // Two-flop synchronisers on both pairs; stage one feeds stage two only.
        // The inputs are taken as synchronous, yet the stages stay: a host edge
        // close to the clock then settles before anything decodes it.
        st_next.sync1  = i_slow_pair;
        st_next.sync2  = st_reg.sync1;
        st_next.prev   = st_reg.sync2;
        st_next.fsync1 = i_fast_pair;
        st_next.fsync2 = st_reg.fsync1;
        st_next.fprev  = st_reg.fsync2;

        // Active path limits: slow or fast
        min_w = i_fast_sel ? CNT_W'(FAST_MIN_CYC) : CNT_W'(SLOW_MIN_CYC);
        min_p = i_fast_sel ? CNT_W'(FAST_PER_CYC) : CNT_W'(SLOW_PER_CYC);
        cur   = i_fast_sel ? st_reg.fsync2 : st_reg.sync2;
        old   = i_fast_sel ? st_reg.fprev  : st_reg.prev;

        // Edges of the selected pair: stage two against the stage after it
        rise_a = cur.a & ~old.a;
        edge_a = cur.a ^ old.a;
        edge_b = cur.b ^ old.b;

        // Decode the chosen form into count strobes. Quadrature counts every
        // single-line edge; an edge on both lines at once carries no direction
        // and is dropped rather than guessed. CW/CCW rises together cancel.
        cnt_en = 1'b0;
        cnt_up = 1'b0;
        case (i_form)
            PRI_FORM_STEP_DIR: begin
                cnt_en = rise_a;
                cnt_up = cur.b;
            end
            PRI_FORM_QUAD: begin
                // Four counts per cycle; a leads b means up
                cnt_en = edge_a ^ edge_b;
                cnt_up = edge_a ? (cur.a ^ cur.b) : ~(cur.a ^ cur.b);
            end
            PRI_FORM_CW_CCW: begin
                cnt_en = (cur.a & ~old.a) ^ (cur.b & ~old.b);
                cnt_up = cur.a & ~old.a;
            end
            default: begin
                // An unknown form code counts nothing
                cnt_en = 1'b0;
                cnt_up = 1'b0;
            end
        endcase

        // Strobe and direction are registered on the edge that moves the count.
        // The position wraps silently at its signed limits; a host that needs
        // a longer travel must track the turns itself.
        st_next.step = cnt_en;
        st_next.up   = cnt_up;
        if (cnt_en) begin
            st_next.pos = cnt_up ? st_reg.pos + 32'sh1 : st_reg.pos - 32'sh1;
        end

        // Width meters on each line of the active pair. They are shared by
        // both pairs to save flops, which is safe while only one pair is used;
        // a swap of i_fast_sel may hand one stale run count to the other pair.
        st_next.meter_a.high_cnt = cur.a ? sat_inc(st_reg.meter_a.high_cnt) : '0;
        st_next.meter_a.low_cnt  = cur.a ? '0 : sat_inc(st_reg.meter_a.low_cnt);
        st_next.meter_b.high_cnt = cur.b ? sat_inc(st_reg.meter_b.high_cnt) : '0;
        st_next.meter_b.low_cnt  = cur.b ? '0 : sat_inc(st_reg.meter_b.low_cnt);
        st_next.gap_cnt = rise_a ? 8'h00 : sat_inc(st_reg.gap_cnt);

        // Sticky error flags; a new event wins over a clear in the same cycle.
        // Limitation: levels are measured in whole cycles, so a level one
        // cycle under the minimum may pass; anything shorter is always caught.
        if (i_err_clear) begin
            st_next.werr = 1'b0;
            st_next.rerr = 1'b0;
            st_next.both = 1'b0;
        end
        // Every level of both lines counts, the direction line included
        if (level_short(cur.a, old.a, st_reg.meter_a, min_w) ||
            level_short(cur.b, old.b, st_reg.meter_b, min_w)) begin
            st_next.werr = 1'b1;
        end
        // Rising steps closer than the rate limit allows. Only the first line
        // is timed; in quadrature it still bounds the pulse rate, in CW/CCW only the clockwise train is bounded.
        if (rise_a && too_short(st_reg.gap_cnt, min_p)) begin
            st_next.rerr = 1'b1;
        end
        // Activity on the idle pair while the other is selected. The flag is
        // sticky because a short burst would otherwise go unseen by software
        // polling it; both pairs stay synchronised so this check can see it.
        if (i_fast_sel ? ((st_reg.sync2 ^ st_reg.prev) != '0)
                       : ((st_reg.fsync2 ^ st_reg.fprev) != '0)) begin
            st_next.both = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // One register stage for the whole struct; every decision sits above
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
            // Lines idle since reset count as long levels, so no false error
            st_reg.meter_a <= '1;
            st_reg.meter_b <= '1;
            st_reg.gap_cnt <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Outputs straight from the state register, so none can glitch;
    // o_count_up means something only while o_count_pulse is high
    assign o_position    = st_reg.pos;
    assign o_count_pulse = st_reg.step;
    assign o_count_up    = st_reg.up;
    assign o_width_error = st_reg.werr;
    assign o_rate_error  = st_reg.rerr;
    assign o_both_active = st_reg.both;

endmodule // pri_receiver

// >>> tb/pri_receiver_asserts.sv
`timescale 1ns/1ps
module pri_receiver_asserts
    import pri_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire pri_form_t         i_form,
    input wire logic              i_fast_sel,
    input wire logic              i_err_clear,
    input wire pri_pair_t         i_slow_pair,
    input wire pri_pair_t         i_fast_pair,
    input wire logic signed [POS_W-1:0] o_position,
    input wire logic              o_count_pulse,
    input wire logic              o_count_up,
    input wire logic              o_width_error,
    input wire logic              o_rate_error,
    input wire logic              o_both_active
);
    // ==========================================================
    // Checks; the window of 3 to 4 edges covers the sync latency
    // ==========================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_pos_track: assert property (!$past(i_rst) |-> o_position == $past(o_position)
        + (o_count_pulse ? (o_count_up ? 32'sd1 : -32'sd1) : 32'sd0)) else $error("bad step");
    a_slow_step: assert property ($rose(i_slow_pair.a) && i_slow_pair.b && !i_fast_sel
        && i_form == PRI_FORM_STEP_DIR |-> ##[3:4] (o_count_pulse && o_count_up)) else $error("slow");
    a_fast_step: assert property ($rose(i_fast_pair.a) && i_fast_pair.b && i_fast_sel
        && i_form == PRI_FORM_STEP_DIR |-> ##[3:4] (o_count_pulse && o_count_up)) else $error("fast");
    a_quad_edge: assert property ($changed(i_slow_pair.a) && !i_fast_sel
        && i_form == PRI_FORM_QUAD |-> ##[3:4] o_count_pulse) else $error("quad");
    a_ccw_down: assert property ($rose(i_slow_pair.b) && !i_slow_pair.a && !i_fast_sel
        && i_form == PRI_FORM_CW_CCW |-> ##[3:4] (o_count_pulse && !o_count_up)) else $error("ccw");
    a_both_seen: assert property ($changed(i_fast_pair) && !i_fast_sel && $stable(i_fast_sel)
        |-> ##[3:4] o_both_active) else $error("both");
    a_err_sticky: assert property (o_width_error && !i_err_clear |=> o_width_error)
        else $error("error lost");
    cover property (o_width_error);
    cover property (o_both_active);
    cover property (o_count_pulse && !o_count_up);
endmodule // pri_receiver_asserts

// >>> tb/pri_host.sv
`timescale 1ns/1ps
module pri_host
    import pri_pkg::*;
(
    input  wire logic i_clk,
    output pri_pair_t o_pair
);
    // ==========================================================
    // Line driver
    // ==========================================================
    initial o_pair = '0;
    // Called at a falling edge; levels hold whole cycles so width is exact
    task automatic put(input pri_pair_t v, input int n);
        o_pair = v;
        repeat (n) @(negedge i_clk);
    endtask
endmodule // pri_host

// >>> tb/pri_receiver_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module pri_receiver_tb
    import pri_pkg::*;
;
    logic                    i_clk, i_rst, i_fast_sel, i_err_clear;
    pri_form_t               i_form;
    pri_pair_t               i_slow_pair, i_fast_pair;
    logic signed [POS_W-1:0] o_position, exp_pos;
    logic                    o_count_pulse, o_count_up, o_width_error, o_rate_error, o_both_active;
    int                      bad_count, tests_run;
    pri_receiver u_pri_receiver (.i_clk(i_clk), .i_rst(i_rst), .i_form(i_form),
        .i_fast_sel(i_fast_sel), .i_err_clear(i_err_clear), .i_slow_pair(i_slow_pair),
        .i_fast_pair(i_fast_pair), .o_position(o_position), .o_count_pulse(o_count_pulse),
        .o_count_up(o_count_up), .o_width_error(o_width_error), .o_rate_error(o_rate_error),
        .o_both_active(o_both_active));
    pri_host u_slow (.i_clk(i_clk), .o_pair(i_slow_pair));
    pri_host u_fast (.i_clk(i_clk), .o_pair(i_fast_pair));
    // ==========================================================
    // Clock, helpers and scenarios
    // ==========================================================
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Plays cnt line pairs, first pair in the top bits; idle host stays still
    task automatic play(input logic fast, input int n, input int cnt, input logic [11:0] s);
        for (int k = cnt - 1; k >= 0; k--) begin
            if (fast) u_fast.put(s[2*k +: 2], n);
            else u_slow.put(s[2*k +: 2], n);
        end
    endtask
    task automatic t_step();
        play(1'b0, 125, 3, 12'b01_11_01);
        `CHK(o_position, exp_pos + 1)
        play(1'b0, 125, 3, 12'b00_10_00);
        `CHK(o_position, exp_pos)
        `CHK({o_width_error, o_rate_error}, 2'b00)
    endtask
    task automatic t_modes();
        i_form = PRI_FORM_QUAD;
        play(1'b0, 125, 4, 12'b10_11_01_00);
        exp_pos = exp_pos + 4;
        `CHK(o_position, exp_pos)
        i_form = PRI_FORM_CW_CCW;
        play(1'b0, 125, 6, 12'b10_00_01_00_01_00);
        exp_pos = exp_pos - 1;
        `CHK(o_position, exp_pos)
    endtask
    // Fast path at its least width, then one pulse too narrow
    task automatic t_fast();
        i_form = PRI_FORM_STEP_DIR;
        i_fast_sel = 1'b1;
        play(1'b1, 7, 5, 12'b01_11_01_11_01);
        exp_pos = exp_pos + 2;
        `CHK({o_width_error, o_position}, {1'b0, exp_pos})
        play(1'b1, 3, 1, 12'b11);
        `CHK({o_count_pulse, o_count_up}, 2'b11)
        play(1'b1, 7, 2, 12'b01_00);
        exp_pos = exp_pos + 1;
        `CHK({o_width_error, o_position}, {1'b1, exp_pos})
        i_err_clear = 1'b1;
        @(negedge i_clk);
        i_err_clear = 1'b0;
        `CHK(o_width_error, 1'b0)
    endtask
    // Fast steps six cycles apart: counted down, but rate and width trip
    task automatic t_rate();
        play(1'b1, 3, 3, 12'b10_00_10);
        exp_pos = exp_pos - 2;
        `CHK({o_count_pulse, o_count_up, o_rate_error}, 3'b101)
        `CHK({o_width_error, o_position}, {1'b1, exp_pos})
        play(1'b1, 7, 1, 12'b00);
        i_err_clear = 1'b1;
        @(negedge i_clk);
        i_err_clear = 1'b0;
        `CHK({o_width_error, o_rate_error}, 2'b00)
    endtask
    // Fast lines move while the slow pair is selected
    task automatic t_both();
        i_fast_sel = 1'b0;
        play(1'b1, 7, 2, 12'b10_00);
        `CHK({o_both_active, o_position}, {1'b1, exp_pos})
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the roughly 2100 cycles the tests take
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        i_form = PRI_FORM_STEP_DIR;
        {i_fast_sel, i_err_clear} = 2'b00;
        {exp_pos, bad_count, tests_run} = '0;
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        t_step();
        t_modes();
        t_fast();
        t_rate();
        t_both();
        stop_test();
    end
endmodule // pri_receiver_tb
bind pri_receiver pri_receiver_asserts u_pri_receiver_asserts (.i_clk, .i_rst, .i_form,
    .i_fast_sel, .i_err_clear, .i_slow_pair, .i_fast_pair, .o_position, .o_count_pulse,
    .o_count_up, .o_width_error, .o_rate_error, .o_both_active);
